//--- rtl/bsb_pkg.sv
package bsb_pkg;

   // Data lane geometry
   localparam int LANE_W = 9;
   localparam int LANES_X18 = 2;
   localparam int LANES_X36 = 4;
   localparam int ADDR_W_X18 = 20;

   // Command encoding on the read/write select and the load strobe
   localparam logic RW_READ = 1'b1;
   localparam logic LOAD_ACTIVE = 1'b0;

   // Reset values
   localparam logic DQ_OE_RST = 1'b0;

   // Pipeline depth in command cycles, and the half-cycle steps from a read command to its word 0
   localparam int PIPE_STAGES = 3;
   localparam int RD_WORD0_HALF = 5;

   // Half-cycle phase: rising edge of the positive clock, then of the negative clock
   typedef enum logic
   {
      BSB_PH_K = 1'b0,
      BSB_PH_KN = 1'b1
   } bsb_phase_t;

endpackage : bsb_pkg

//--- rtl/bsb_lane_if.sv
`timescale 1ns/1ps

interface bsb_lane_if #(
   parameter int LANES = 2
);
   logic [LANES*9-1:0] old_word;
   logic [LANES*9-1:0] new_word;
   logic [LANES-1:0] sel_n;
   logic [LANES*9-1:0] merged;
   logic any_lane;

   modport merger (
      input old_word,
      input new_word,
      input sel_n,
      output merged,
      output any_lane
   );

   modport user (
      output old_word,
      output new_word,
      output sel_n,
      input merged,
      input any_lane
   );
endinterface : bsb_lane_if

//--- rtl/bsb_lane_merge.sv
`timescale 1ns/1ps

module bsb_lane_merge #(
   parameter int LANES = 2
) (
   bsb_lane_if.merger lane
);
   import bsb_pkg::*;

   // A lane with its select high keeps the stored bits
   genvar g;
   generate
      for (g = 0; g < LANES; g++)
      begin : g_lane
         assign lane.merged[g*LANE_W +: LANE_W] = lane.sel_n[g] ?
            lane.old_word[g*LANE_W +: LANE_W] : lane.new_word[g*LANE_W +: LANE_W];
      end
   endgenerate

   // All selects high means this word writes nothing
   assign lane.any_lane = ~&lane.sel_n;

endmodule : bsb_lane_merge

//--- rtl/bsb_sram_if.sv
`timescale 1ns/1ps

module bsb_sram_if #(
   parameter int LANES = bsb_pkg::LANES_X18,
   parameter int ADDR_W = bsb_pkg::ADDR_W_X18
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic srst_i,
   // Half-cycle enable; low while the memory clocks are stopped
   input wire logic clk_run_i,
   // Command
   input wire logic load_strobe_n_i,
   input wire logic rw_i,
   input wire logic [ADDR_W-1:0] addr_i,
   // Data pins and lane selects
   input wire logic [LANES*bsb_pkg::LANE_W-1:0] dq_i,
   input wire logic [LANES-1:0] byte_lane_write_select_n_i,
   output logic [LANES*bsb_pkg::LANE_W-1:0] dq_o,
   output logic dq_oe_o,
   // Current half-cycle phase
   output bsb_pkg::bsb_phase_t phase_o
);
   import bsb_pkg::*;

   localparam int DW = LANES * LANE_W;
   localparam int DEPTH = 2 ** ADDR_W;

   // Refused at elaboration: the lane merge and the flop array serve only these sizes
   if (!(LANES == LANES_X18 || LANES == LANES_X36) || ADDR_W < 1 || ADDR_W > 24)
   begin : g_bad_params
      $error("bsb_sram_if: unsupported LANES or ADDR_W");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Phase divider: one core cycle per clock edge

   bsb_phase_t ph_r;
   logic at_k;
   logic at_kn;

   assign at_k = clk_run_i && (ph_r == BSB_PH_K);
   assign at_kn = clk_run_i && (ph_r == BSB_PH_KN);

   always_ff @(posedge core_clk_i)
   begin
      if (srst_i)
         ph_r <= BSB_PH_K;
      else if (clk_run_i)
         ph_r <= (ph_r == BSB_PH_K) ? BSB_PH_KN : BSB_PH_K;
   end

   assign phase_o = ph_r;

   ////////////////////////////////////////////////////////////////////////////
   // Command pipeline, one stage per positive-clock cycle

   logic [PIPE_STAGES:1] vld_r;
   logic [PIPE_STAGES:1] rd_r;
   logic [ADDR_W-1:0] addr_r [1:PIPE_STAGES];

   always_ff @(posedge core_clk_i)
   begin
      if (srst_i)
      begin
         vld_r <= '0;
         rd_r <= '0;
      end
      else if (at_k)
      begin
         vld_r <= {vld_r[PIPE_STAGES-1:1], load_strobe_n_i == LOAD_ACTIVE};
         rd_r <= {rd_r[PIPE_STAGES-1:1], rw_i == RW_READ};
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (at_k)
      begin
         addr_r[1] <= addr_i;
         for (int i = 2; i <= PIPE_STAGES; i++)
            addr_r[i] <= addr_r[i-1];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Write path: word 0 at the next positive edge, word 1 at the negative edge

   logic [DW-1:0] mem [0:DEPTH-1];
   logic wr_go;
   logic [ADDR_W-1:0] wr_addr;

   // Stage 1 still holds the command at the positive edge of t+1; by the
   // negative edge it has moved to stage 2.
   assign wr_go = at_k ? (vld_r[1] && !rd_r[1]) : (at_kn && vld_r[2] && !rd_r[2]);
   assign wr_addr = at_k ? addr_r[1] : ADDR_W'(addr_r[2] + 1'b1);

   bsb_lane_if #(.LANES(LANES)) lane_bus ();

   assign lane_bus.old_word = mem[wr_addr];
   assign lane_bus.new_word = dq_i;
   assign lane_bus.sel_n = byte_lane_write_select_n_i;

   bsb_lane_merge #(.LANES(LANES)) u_merge (
      .lane(lane_bus.merger)
   );

   always_ff @(posedge core_clk_i)
   begin
      if (wr_go && lane_bus.any_lane)
         mem[wr_addr] <= lane_bus.merged;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read path: stage 3 drives word 0 at K# of t+2 and word 1 at K of t+3

   logic [ADDR_W-1:0] rd_addr;
   logic [DW-1:0] dq_nxt;

   assign rd_addr = (ph_r == BSB_PH_K) ? ADDR_W'(addr_r[3] + 1'b1) : addr_r[3];
   // Writes land in the array at the edge that samples their data, so a read of a
   // just-written word already sees it; no stale copy can be returned.
   assign dq_nxt = mem[rd_addr];

   always_ff @(posedge core_clk_i)
   begin
      if (srst_i)
      begin
         dq_oe_o <= DQ_OE_RST;
         dq_o <= '0;
      end
      else if (clk_run_i && vld_r[3] && rd_r[3])
      begin
         dq_o <= dq_nxt;
         dq_oe_o <= 1'b1;
      end
      else if (at_kn)
         dq_oe_o <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   // Helper state for the checks: the word under the write address one edge back,
   // and the address that word 0 of the current write burst went to.
   logic [ADDR_W-1:0] chk_addr_r;
   logic [DW-1:0] chk_word_r;
   logic [ADDR_W-1:0] w0_addr_r;

   always_ff @(posedge core_clk_i)
   begin
      chk_addr_r <= wr_addr;
      chk_word_r <= mem[wr_addr];
      if (at_k && wr_go)
         w0_addr_r <= wr_addr;
   end

   sequence s_rd_cmd;
      at_k && load_strobe_n_i == LOAD_ACTIVE && rw_i == RW_READ;
   endsequence

   sequence s_run5;
      clk_run_i [*5];
   endsequence

   a_reset_float: assert property (@(posedge core_clk_i)
      srst_i |=> !dq_oe_o)
      else $error("data drivers on after reset");

   a_read_latency: assert property (@(posedge core_clk_i) disable iff (srst_i)
      s_rd_cmd ##1 s_run5 |=> dq_oe_o)
      else $error("read word 0 not driven at half-step five");

   a_read_early: assert property (@(posedge core_clk_i) disable iff (srst_i)
      s_rd_cmd ##1 (clk_run_i && !vld_r[2]) [*2] ##1 (clk_run_i && !vld_r[3]) [*2]
      |=> !dq_oe_o)
      else $error("read data driven before its latency");

   a_clock_stop_hold: assert property (@(posedge core_clk_i) disable iff (srst_i)
      !clk_run_i |=> $stable(dq_o) && $stable(dq_oe_o) && $stable(ph_r) && $stable(vld_r))
      else $error("state changed while clocks stopped");

   a_nop_no_start: assert property (@(posedge core_clk_i) disable iff (srst_i)
      at_k && load_strobe_n_i != LOAD_ACTIVE |=> !vld_r[1])
      else $error("operation started without load strobe");

   a_float_after_read: assert property (@(posedge core_clk_i) disable iff (srst_i)
      at_kn && !(vld_r[3] && rd_r[3]) |=> !dq_oe_o)
      else $error("outputs still driven after read burst");

   a_burst_addr: assert property (@(posedge core_clk_i) disable iff (srst_i)
      at_kn && vld_r[2] && !rd_r[2] |-> wr_go && wr_addr == ADDR_W'(w0_addr_r + 1'b1))
      else $error("second write word not at address plus one");

   a_masked_write: assert property (@(posedge core_clk_i) disable iff (srst_i)
      wr_go && &byte_lane_write_select_n_i |=> mem[chk_addr_r] == chk_word_r)
      else $error("word changed with every lane deselected");

   a_phase_toggle: assert property (@(posedge core_clk_i) disable iff (srst_i)
      clk_run_i |=> ph_r != $past(ph_r))
      else $error("phase did not alternate");

endmodule : bsb_sram_if

//--- verif/bsb_ctrl_model.sv
`timescale 1ns/1ps

module bsb_ctrl_model #(
   parameter int AW = 4,
   parameter int LN = 2
) (
   // Clock and device phase
   input wire logic core_clk_i,
   input bsb_pkg::bsb_phase_t phase_i,
   // Toward the device
   output logic run_o,
   output logic ld_n_o,
   output logic rw_o,
   output logic [AW-1:0] addr_o,
   output logic [LN*9-1:0] wd_o,
   output logic [LN-1:0] sel_n_o
);
   import bsb_pkg::*;

   // Clock stop is modelled by the run enable; both clocks count as parked high
   initial
   begin
      run_o = 1'b1;
      ld_n_o = 1'b1;
      rw_o = 1'b0;
      addr_o = '0;
      wd_o = '0;
      sel_n_o = '1;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Waits for a negative-clock edge so the next edge, a positive one, samples it;
   // after a read this wait alone leaves only one idle cycle before a write
   // The phase is read once it has settled after an edge, never in the edge's own step
   task automatic cmd(input logic rd, input logic [AW-1:0] a);
      @(posedge core_clk_i);
      #1;
      while (phase_i !== BSB_PH_KN)
      begin
         @(posedge core_clk_i);
         #1;
      end
      @(posedge core_clk_i);
      ld_n_o <= LOAD_ACTIVE;
      rw_o <= rd;
      addr_o <= a;
      @(posedge core_clk_i);
      ld_n_o <= ~LOAD_ACTIVE;
      addr_o <= ~a;
   endtask : cmd

   task automatic wr(input logic [AW-1:0] a, input logic [LN*9-1:0] d0, d1,
                     input logic [LN-1:0] s0, s1);
      cmd(~RW_READ, a);
      @(posedge core_clk_i);
      wd_o <= d0;
      sel_n_o <= s0;
      @(posedge core_clk_i);
      wd_o <= d1;
      sel_n_o <= s1;
      // Released data shows the inverse so stale values cannot pass
      @(posedge core_clk_i);
      wd_o <= ~d1;
      sel_n_o <= '1;
   endtask : wr
endmodule : bsb_ctrl_model

//--- verif/tb_burst_sram_bus_interface.sv
`timescale 1ns/1ps

`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
   $display("ERROR %0t ns: got %h want %h", $time, a, b); end end

module tb_burst_sram_bus_interface;
   import bsb_pkg::*;

   logic core_clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic run, ld_n, rw, oe;
   logic [3:0] addr;
   logic [17:0] dq_w, dq_r;
   logic [1:0] sel_n;
   bsb_phase_t ph;
   logic [17:0] shadow [16];
   int fail_count = 0;
   int n_checks = 0;

   always #25 core_clk_i = ~core_clk_i;

   bsb_ctrl_model m (.core_clk_i(core_clk_i), .phase_i(ph), .run_o(run), .ld_n_o(ld_n),
      .rw_o(rw), .addr_o(addr), .wd_o(dq_w), .sel_n_o(sel_n));

   bsb_sram_if #(.LANES(2), .ADDR_W(4)) u_dut (.core_clk_i(core_clk_i), .srst_i(srst_i),
      .clk_run_i(run), .load_strobe_n_i(ld_n), .rw_i(rw), .addr_i(addr), .dq_i(dq_w),
      .byte_lane_write_select_n_i(sel_n), .dq_o(dq_r), .dq_oe_o(oe), .phase_o(ph));

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [17:0] mrg(input logic [17:0] o, n, input logic [1:0] s);
      for (int g = 0; g < 2; g++)
         if (s[g] == 1'b0)
            o[9*g +: 9] = n[9*g +: 9];
      return o;
   endfunction : mrg

   task automatic wr(input logic [3:0] a, input logic [17:0] d0, d1, input logic [1:0] s0, s1);
      m.wr(a, d0, d1, s0, s1);
      shadow[a] = mrg(shadow[a], d0, s0);
      shadow[a + 4'h1] = mrg(shadow[a + 4'h1], d1, s1);
   endtask : wr

   // Optional clock stop right after the first read word
   task automatic rd(input logic [3:0] a, input bit stp);
      m.cmd(RW_READ, a);
      repeat (4) @(posedge core_clk_i);
      #1 `CHK(oe, 1'b0)
      @(posedge core_clk_i);
      if (stp)
         m.run_o <= 1'b0;
      #1 `CHK(dq_r, shadow[a])
      `CHK(oe, 1'b1)
      if (stp)
      begin
         repeat (3) @(posedge core_clk_i);
         #1 `CHK(dq_r, shadow[a])
         `CHK(oe, 1'b1)
         @(posedge core_clk_i);
         m.run_o <= 1'b1;
      end
      @(posedge core_clk_i);
      #1 `CHK(dq_r, shadow[a + 4'h1])
      @(posedge core_clk_i);
      #1 `CHK(oe, 1'b0)
   endtask : rd

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_basic();
      wr(4'h3, 18'h2a5c3, 18'h1f00e, 2'h0, 2'h0);
      rd(4'h3, 1'b0);
   endtask : t_basic

   // Every select pair on each word, the two words differing
   task automatic t_lanes();
      for (int i = 0; i < 4; i++)
      begin
         wr(4'h8, 18'h3ffff, 18'h00000, 2'h0, 2'h0);
         wr(4'h8, 18'h12345 + 18'(i), 18'h2abcd, 2'(i), ~2'(i));
         rd(4'h8, 1'b0);
      end
   endtask : t_lanes

   // Read issued the cycle after a write to the same word must return the new data
   task automatic t_fwd();
      m.cmd(~RW_READ, 4'h5);
      @(posedge core_clk_i);
      m.ld_n_o <= LOAD_ACTIVE;
      m.rw_o <= RW_READ;
      m.addr_o <= 4'h5;
      m.wd_o <= 18'h2d1e7;
      m.sel_n_o <= 2'h0;
      @(posedge core_clk_i);
      m.ld_n_o <= ~LOAD_ACTIVE;
      m.wd_o <= 18'h0c3b9;
      @(posedge core_clk_i);
      m.wd_o <= 18'h33c46;
      m.sel_n_o <= 2'h3;
      shadow[5] = 18'h2d1e7;
      shadow[6] = 18'h0c3b9;
      repeat (4) @(posedge core_clk_i);
      #1 `CHK(dq_r, 18'h2d1e7)
      `CHK(oe, 1'b1)
      @(posedge core_clk_i);
      #1 `CHK(dq_r, 18'h0c3b9)
      @(posedge core_clk_i);
      #1 `CHK(oe, 1'b0)
   endtask : t_fwd

   task automatic t_wrap();
      wr(4'hf, 18'h0f0f0, 18'h30303, 2'h0, 2'h0);
      rd(4'hf, 1'b1);
   endtask : t_wrap

   // Strobe high with read select high must start nothing
   task automatic t_idle();
      @(posedge core_clk_i);
      m.rw_o <= RW_READ;
      repeat (8)
      begin
         @(posedge core_clk_i);
         #1 `CHK(oe, 1'b0)
      end
   endtask : t_idle

   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : complete_run

   initial
   begin
      #100000;
      fail_count++;
      complete_run();
   end

   initial
   begin
      repeat (2) @(posedge core_clk_i);
      srst_i <= 1'b0;
      #1 `CHK(oe, 1'b0)
      `CHK(ph, BSB_PH_K)
      `CHK(dq_r, 18'h00000)
      t_basic();
      t_fwd();
      t_lanes();
      t_wrap();
      t_idle();
      complete_run();
   end
endmodule : tb_burst_sram_bus_interface
